// [design/uhd_pkg.sv]
// Package: register map, field layout and timing constants of the alternate-function block
package uhd_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [3:0] ADDR_AFC = 4'h0;
  localparam logic [3:0] ADDR_EXT = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  // ----------------------------------------
  // Alternate function control fields
  // ----------------------------------------
  localparam int AFC_CONCURRENT = 0;
  localparam int AFC_IR = 1;
  localparam int AFC_HD = 2;
  localparam int AFC_LG = 3;
  localparam int AFC_SNOOP = 4;
  localparam int AFC_DLY_LO = 5;
  localparam int AFC_DLY_HI = 7;
  localparam int EXT_DLY_TOP = 0;
  localparam logic [7:0] AFC_RESET = 8'h00;
  localparam logic [0:0] EXT_RESET = 1'h0;

  // ----------------------------------------
  // Status fields
  // ----------------------------------------
  localparam int ST_DRIVER = 0;
  localparam int ST_TXGO = 1;
  localparam int ST_HOLDING = 2;
  localparam int ST_RXEN = 3;
  localparam int ST_TIMEOUT = 4;
  localparam int ST_TXIRQ = 5;
  localparam int ST_DECRX = 6;

  // ----------------------------------------
  // Timing in sixteen-times clock ticks
  // ----------------------------------------
  localparam logic [3:0] LAST_TICK = 4'hf;
  localparam logic [3:0] IR_PULSE_ON = 4'h6;
  localparam logic [3:0] IR_PULSE_OFF = 4'h9;
  localparam logic [4:0] DEC_LOW_TICKS = 5'h10;

  // ----------------------------------------
  // Bus responses
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    DE_IDLE = 4'h1,
    DE_LEAD = 4'h2,
    DE_ACTIVE = 4'h4,
    DE_HOLD = 4'h8
  } uhd_de_e;

endpackage

// [design/uhd_alt_func.sv]
// Module: half-duplex driver enable, receive gating and infrared coding of one UART channel
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps

module uhd_alt_func
  import uhd_pkg::*;
#(
  parameter int AddrW = 4,
  parameter int DelayW = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [AddrW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AddrW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic sixteenXBitClock,
  input wire logic txFifoEmpty,
  input wire logic txShiftEmpty,
  input wire logic txFifoWrite,
  input wire logic loopbackControlBit,
  input wire logic coreTxd,
  input wire logic rxPin,
  output logic lineDriverEnableOut,
  output logic txGo,
  output logic txIrqPermit,
  output logic rxEnable,
  output logic rxTimeoutEnable,
  output logic txPin,
  output logic coreRxd
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic isMapped(input logic [AddrW-1:0] addr);
    isMapped = (addr == ADDR_AFC) || (addr == ADDR_EXT) || (addr == ADDR_STATUS);
  endfunction

  logic [7:0] altFunctionControl;
  logic [0:0] delayTop;
  logic hdMode;
  logic irMode;
  logic largeBlock;
  logic snoop;
  logic [DelayW-1:0] holdDelay;
  logic pending;
  uhd_de_e stateQ;
  uhd_de_e next_state;
  logic [3:0] subCnt;
  logic [DelayW-1:0] holdCnt;
  logic bitTick;
  logic [3:0] encPhase;
  logic rxPrev;
  logic rxFall;
  logic [4:0] decCnt;
  logic [AddrW-1:0] awAddrQ;
  logic [7:0] wByteQ;
  logic wLaneQ;
  logic [7:0] statusByte;

  assign hdMode = altFunctionControl[AFC_HD];
  assign irMode = altFunctionControl[AFC_IR];
  assign largeBlock = altFunctionControl[AFC_LG];
  assign snoop = altFunctionControl[AFC_SNOOP];
  assign holdDelay = {delayTop, altFunctionControl[AFC_DLY_HI:AFC_DLY_LO]};
  assign pending = !txFifoEmpty || !txShiftEmpty;
  assign bitTick = sixteenXBitClock && (subCnt == LAST_TICK);
  assign rxFall = rxPrev && !rxPin;

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  // Address and data are taken in either order; the write lands once both are held
  always_ff @(posedge clock) begin
    if (rst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      awAddrQ <= '0;
      wByteQ <= 8'h00;
      wLaneQ <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        awAddrQ <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wByteQ <= wdata[7:0];
        wLaneQ <= wstrb[0];
      end
      if (!awready && !wready && !bvalid) begin
        bvalid <= 1'b1;
        bresp <= isMapped(awAddrQ) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      altFunctionControl <= AFC_RESET;
      delayTop <= EXT_RESET;
    end else if (!awready && !wready && !bvalid && wLaneQ) begin
      if (awAddrQ == ADDR_AFC) begin
        altFunctionControl <= wByteQ;
      end
      if (awAddrQ == ADDR_EXT) begin
        delayTop <= wByteQ[EXT_DLY_TOP];
      end
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  always_comb begin
    statusByte = 8'h00;
    statusByte[ST_DRIVER] = lineDriverEnableOut;
    statusByte[ST_TXGO] = txGo;
    statusByte[ST_HOLDING] = (stateQ == DE_HOLD);
    statusByte[ST_RXEN] = rxEnable;
    statusByte[ST_TIMEOUT] = rxTimeoutEnable;
    statusByte[ST_TXIRQ] = txIrqPermit;
    statusByte[ST_DECRX] = coreRxd;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      if (araddr == ADDR_AFC) begin
        rdata <= {24'h00_0000, altFunctionControl};
      end else if (araddr == ADDR_EXT) begin
        rdata <= {31'h0000_0000, delayTop};
      end else if (araddr == ADDR_STATUS) begin
        rdata <= {24'h00_0000, statusByte};
      end else begin
        rdata <= 32'h0000_0000;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // Driver enable sequencing
  // ----------------------------------------
  always_comb begin
    next_state = stateQ;
    case (stateQ)
      DE_IDLE: begin
        if (hdMode && pending) begin
          next_state = DE_LEAD;
        end
      end
      DE_LEAD: begin
        if (bitTick) begin
          next_state = DE_ACTIVE;
        end
      end
      DE_ACTIVE: begin
        if (!pending && !txFifoWrite) begin
          next_state = (holdDelay == '0) ? DE_IDLE : DE_HOLD;
        end
      end
      DE_HOLD: begin
        if (pending || txFifoWrite) begin
          next_state = DE_ACTIVE;
        end else if (bitTick && (holdCnt == holdDelay - 1'b1)) begin
          next_state = DE_IDLE;
        end
      end
      default: begin
        next_state = DE_IDLE;
      end
    endcase
    if (!hdMode) begin
      next_state = DE_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      stateQ <= DE_IDLE;
    end else begin
      stateQ <= next_state;
    end
  end

  // Phase within the current bit time; restarts on each state change
  always_ff @(posedge clock) begin
    if (rst || (next_state != stateQ)) begin
      subCnt <= 4'h0;
    end else if (sixteenXBitClock) begin
      subCnt <= subCnt + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || stateQ != DE_HOLD || pending || txFifoWrite) begin
      holdCnt <= '0;
    end else if (bitTick) begin
      holdCnt <= holdCnt + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      lineDriverEnableOut <= 1'b0;
      txGo <= 1'b0;
    end else begin
      lineDriverEnableOut <= (next_state != DE_IDLE);
      // Outside half-duplex the transmitter is never held back
      txGo <= !hdMode || (next_state == DE_ACTIVE) || (next_state == DE_HOLD);
    end
  end

  // ----------------------------------------
  // Interrupt and receiver gating
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      txIrqPermit <= 1'b1;
      rxEnable <= 1'b1;
      rxTimeoutEnable <= 1'b0;
    end else begin
      // In half-duplex, held until both shift register and FIFO drain when large-block is off
      txIrqPermit <= !hdMode || largeBlock || !pending;
      // Loopback always stores; snoop matters only in half-duplex or infrared
      rxEnable <= loopbackControlBit || snoop || !(hdMode || irMode);
      rxTimeoutEnable <= snoop;
    end
  end

  // ----------------------------------------
  // Infrared encoder
  // ----------------------------------------
  // Only the slow single-bit scheme; every frame bit coded alike
  always_ff @(posedge clock) begin
    if (rst || coreTxd) begin
      encPhase <= 4'h0;
    end else if (sixteenXBitClock) begin
      encPhase <= encPhase + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      txPin <= 1'b0;
    end else if (!irMode) begin
      txPin <= coreTxd;
    end else if (coreTxd) begin
      txPin <= 1'b0;
    end else if (sixteenXBitClock) begin
      txPin <= (encPhase >= IR_PULSE_ON) && (encPhase < IR_PULSE_OFF);
    end
  end

  // ----------------------------------------
  // Infrared decoder
  // ----------------------------------------
  // Works from falling edges: a positive pulse decodes on its trailing edge
  always_ff @(posedge clock) begin
    if (rst) begin
      rxPrev <= 1'b1;
      decCnt <= 5'h00;
    end else begin
      rxPrev <= rxPin;
      if (rxFall) begin
        decCnt <= DEC_LOW_TICKS;
      end else if (sixteenXBitClock && decCnt != 5'h00) begin
        decCnt <= decCnt - 5'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      coreRxd <= 1'b1;
    end else begin
      coreRxd <= irMode ? (decCnt == 5'h00) : rxPin;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_leadStart;
    stateQ == DE_IDLE && hdMode && pending;
  endsequence
  sequence s_leadEnd;
    lineDriverEnableOut && !txGo;
  endsequence
  property p_leadBit;
    s_leadStart |=> s_leadEnd;
  endproperty
  a_leadBit: assert property (p_leadBit) else $error("driver not raised ahead of data");

  property p_activeHigh;
    stateQ == DE_ACTIVE && hdMode && pending |=> lineDriverEnableOut;
  endproperty
  a_activeHigh: assert property (p_activeHigh) else $error("driver low with data");

  property p_writeCancel;
    stateQ == DE_HOLD && hdMode && txFifoWrite |=> stateQ == DE_ACTIVE && holdCnt == '0;
  endproperty
  a_writeCancel: assert property (p_writeCancel) else $error("hold not cancelled");

  property p_holdRelease;
    stateQ == DE_HOLD && hdMode && !pending && !txFifoWrite && bitTick
      && holdCnt == holdDelay - 1'b1 |=> !lineDriverEnableOut;
  endproperty
  a_holdRelease: assert property (p_holdRelease) else $error("hold overran");

  property p_noTimeout;
    !snoop |=> !rxTimeoutEnable;
  endproperty
  a_noTimeout: assert property (p_noTimeout) else $error("timeout without snoop");

  property p_blockRx;
    !loopbackControlBit && !snoop && (hdMode || irMode) |=> !rxEnable;
  endproperty
  a_blockRx: assert property (p_blockRx) else $error("receiver not blocked");

  property p_fullDuplex;
    !hdMode && !irMode |=> rxEnable;
  endproperty
  a_fullDuplex: assert property (p_fullDuplex) else $error("full duplex rx off");

  property p_txIrqHold;
    hdMode && !largeBlock && !txShiftEmpty |=> !txIrqPermit;
  endproperty
  a_txIrqHold: assert property (p_txIrqHold) else $error("tx irq not withheld");

  property p_irIdle;
    irMode && coreTxd |=> !txPin;
  endproperty
  a_irIdle: assert property (p_irIdle) else $error("ir output not idle low");

  property p_irDecode;
    irMode && rxFall ##1 irMode |=> !coreRxd;
  endproperty
  a_irDecode: assert property (p_irDecode) else $error("edge not decoded as zero");
endmodule // uhd_alt_func

// [test/uhd_line_model.sv]
// Far-side model: RS-485 transceiver bus and infrared optics of one channel
`timescale 1ns/10ps

// ----------------------------------------
// Line model
// ----------------------------------------
module uhd_line_model (
  input wire logic txPin,
  input wire logic lineDriverEnableOut,
  input wire logic irMode,
  input wire logic invertRx,
  input wire logic remoteBit,
  output logic rxPin
);
  logic busLevel;

  // Infrared echoes txPin; on the pair own driver wins, otherwise the remote node drives it
  always_comb begin
    if (irMode) begin
      busLevel = txPin;
    end else if (lineDriverEnableOut) begin
      busLevel = txPin;
    end else begin
      busLevel = remoteBit;
    end
  end

  // Most photodiode stages invert, so both pulse polarities are offered
  assign rxPin = invertRx ? ~busLevel : busLevel;
endmodule // uhd_line_model

// [test/uhd_alt_func_bench.sv]
// Bench for the alternate-function block: bus, driver enable, receive gating, infrared
`timescale 1ns/10ps

module uhd_alt_func_bench;
  import uhd_pkg::*;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic sixteenXBitClock = 1'h0, txFifoEmpty = 1'h1, txShiftEmpty = 1'h1, txFifoWrite = 1'h0;
  logic loopbackControlBit = 1'h0, coreTxd = 1'h1, remoteBit = 1'h1;
  logic invertRx = 1'h0, irMode = 1'h0, clr = 1'h0, prevTx = 1'h0;
  logic rxPin, lineDriverEnableOut, txGo, txIrqPermit, rxEnable, rxTimeoutEnable, txPin, coreRxd;
  logic [1:0] tickDiv = 2'h0;
  logic [7:0] modes [6] = '{8'h10, 8'h14, 8'h12, 8'h00, 8'h04, 8'h02};
  int nTicks = 0, n_fail = 0, checked = 0, pulses = 0, hiCycles = 0, rxLow = 0, riseTick = -1;

  uhd_alt_func DUT (.clock, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .sixteenXBitClock, .txFifoEmpty, .txShiftEmpty, .txFifoWrite, .loopbackControlBit, .coreTxd,
    .rxPin, .lineDriverEnableOut, .txGo, .txIrqPermit, .rxEnable, .rxTimeoutEnable, .txPin,
    .coreRxd);
  uhd_line_model far_end (.txPin, .lineDriverEnableOut, .irMode, .invertRx, .remoteBit, .rxPin);

  initial begin
    forever #12.5 clock = ~clock;
  end

  // ----------------------------------------
  // Baud tick every fourth clock, wire monitor
  // ----------------------------------------
  always @(posedge clock) begin
    tickDiv <= tickDiv + 2'h1;
    sixteenXBitClock <= tickDiv == 2'h3;
    if (sixteenXBitClock) nTicks <= nTicks + 1;
    prevTx <= txPin;
    if (clr) begin
      pulses <= 0;
      hiCycles <= 0;
      rxLow <= 0;
      riseTick <= -1;
    end else begin
      if (txPin) hiCycles <= hiCycles + 1;
      if (!coreRxd) rxLow <= rxLow + 1;
      if (txPin && !prevTx) pulses <= pulses + 1;
      if (txPin && !prevTx && riseTick < 0) riseTick <= nTicks;
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic exp_rx(input logic [7:0] v, input logic lp);
    return lp | v[AFC_SNOOP] | !(v[AFC_HD] | v[AFC_IR]);
  endfunction

  // Start bit plus the data zeros of one frame
  function automatic int zeros_of(input logic [7:0] v);
    return 9 - $countones(v);
  endfunction

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic timed(input logic stuck);
    if (stuck) begin
      check("wait", 1, 0);
      report_and_stop();
    end
  endtask

  task automatic wait_ticks(input int k);
    int t;
    int n;
    t = nTicks;
    for (n = 0; n < 8 * k + 8 && nTicks - t < k; n++) @(posedge clock);
    timed(nTicks - t < k);
  endtask

  task automatic axi_write(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw, w, b;
    int n;
    // An edge between transfers, so no strobe is assigned twice in one step
    @(posedge clock);
    aw = 1'h1;
    w = 1'h1;
    b = 1'h1;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 50 && b; n++) begin
      @(posedge clock);
      if (aw && awready) begin
        aw = 1'h0;
        awvalid <= 1'h0;
      end
      if (w && wready) begin
        w = 1'h0;
        wvalid <= 1'h0;
      end
      if (bvalid) begin
        b = 1'h0;
        bready <= 1'h0;
        check("bresp", bresp, er);
      end
    end
    timed(b);
  endtask

  task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar, r;
    int n;
    @(posedge clock);
    ar = 1'h1;
    r = 1'h1;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 50 && r; n++) begin
      @(posedge clock);
      if (ar && arready) begin
        ar = 1'h0;
        arvalid <= 1'h0;
      end
      if (rvalid) begin
        r = 1'h0;
        rready <= 1'h0;
        check("rdata", rdata, ed);
        check("rresp", rresp, er);
      end
    end
    timed(r);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int n, run, d, t0, b, zeros;
    logic [7:0] v;
    logic [3:0] dly;
    void'($urandom(42));
    repeat (20) @(posedge clock);
    rst <= 1'h0;
    repeat (2) @(posedge clock);
    #1;
    check("driver", lineDriverEnableOut, 0);
    check("timeout", rxTimeoutEnable, 0);
    axi_read(ADDR_STATUS, 32'h0000_006a, RESP_OKAY);
    axi_read(4'hc, 32'h0000_0000, RESP_SLVERR);
    axi_write(4'hc, 8'hff, RESP_SLVERR);
    v = 8'($urandom);
    axi_write(ADDR_AFC, v, RESP_OKAY);
    axi_read(ADDR_AFC, {24'h00_0000, v}, RESP_OKAY);
    // Low lane off: the write is answered but leaves the register alone
    wstrb <= 4'h0;
    axi_write(ADDR_AFC, ~v, RESP_OKAY);
    wstrb <= 4'hf;
    axi_read(ADDR_AFC, {24'h00_0000, v}, RESP_OKAY);
    // Every receive-gating mode, loopback off then on
    for (n = 0; n < 12; n++) begin
      loopbackControlBit <= n >= 6;
      axi_write(ADDR_AFC, modes[n % 6], RESP_OKAY);
      repeat (2) @(posedge clock);
      #1;
      check("rxen", rxEnable, exp_rx(modes[n % 6], n >= 6));
      check("timeout", rxTimeoutEnable, modes[n % 6][AFC_SNOOP]);
    end
    loopbackControlBit <= 1'h0;
    // Half-duplex: lead bit, hold count, cancel, large-block interrupts
    for (run = 0; run < 3; run++) begin
      dly = (run == 2) ? 4'h0 : 4'($urandom_range(15, 2));
      d = dly;
      v = {dly[2:0], run == 0, run == 0, 3'h4};
      axi_write(ADDR_EXT, {7'h00, dly[3]}, RESP_OKAY);
      axi_read(ADDR_EXT, {31'h0000_0000, dly[3]}, RESP_OKAY);
      axi_write(ADDR_AFC, v, RESP_OKAY);
      t0 = nTicks;
      txFifoEmpty <= 1'h0;
      repeat (2) @(posedge clock);
      #1;
      check("driver", lineDriverEnableOut, 1);
      check("go", txGo, 0);
      check("irq", txIrqPermit, run == 0);
      for (n = 0; n < 400 && txGo !== 1'h1; n++) @(posedge clock);
      timed(txGo !== 1'h1);
      check("lead", (nTicks - t0) inside {[16 : 18]}, 1);
      txShiftEmpty <= 1'h0;
      txFifoEmpty <= 1'h1;
      if (run == 0) begin
        // Host drops large-block after the last load
        axi_write(ADDR_AFC, v & 8'hf7, RESP_OKAY);
        coreTxd <= 1'h0;
        repeat (4) @(posedge clock);
        #1;
        check("snoop", coreRxd, 0);
        coreTxd <= 1'h1;
      end
      repeat (2) @(posedge clock);
      #1;
      check("irq", txIrqPermit, 0);
      check("rxen", rxEnable, run == 0);
      txShiftEmpty <= 1'h1;
      t0 = nTicks;
      if (d > 1) begin
        wait_ticks(8);
        txFifoWrite <= 1'h1;
        @(posedge clock);
        txFifoWrite <= 1'h0;
        t0 = nTicks;
      end
      for (n = 0; n < 2000 && lineDriverEnableOut !== 1'h0; n++) @(posedge clock);
      timed(lineDriverEnableOut !== 1'h0);
      check("hold", (nTicks - t0) inside {[d * 16 : d * 16 + 2]}, 1);
      check("irq", txIrqPermit, 1);
    end
    // Infrared: one frame per receive polarity
    for (run = 0; run < 2; run++) begin
      irMode <= 1'h1;
      invertRx <= run[0];
      axi_write(ADDR_AFC, 8'h12, RESP_OKAY);
      wait_ticks(20);
      v = 8'($urandom);
      zeros = zeros_of(v);
      clr <= 1'h1;
      @(posedge clock);
      clr <= 1'h0;
      t0 = nTicks;
      for (b = 0; b < 10; b++) begin
        coreTxd <= (b == 0) ? 1'h0 : ((b == 9) ? 1'h1 : v[b - 1]);
        wait_ticks(16);
      end
      wait_ticks(32);
      check("pulses", pulses, zeros);
      check("width", hiCycles, zeros * 12);
      check("phase", (riseTick - t0) inside {[6 : 9]}, 1);
      check("decode", rxLow inside {[zeros * 60 - 8 : zeros * 64 + 8]}, 1);
    end
    report_and_stop();
  end
endmodule // uhd_alt_func_bench
